// file: src/gpio_pad_config_ctrl.sv
// Purpose: pad configuration, page register and strobe-to-latch logic
// Assumes: one CPU clock; persistent latches modelled as flip-flops
// Notes:   read data is registered one cycle after rdEn
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pad_regs.svh"

module gpio_pad_config_ctrl #(
  parameter int UPDATE_CLOCKS = `PAD_UPDATE_CLOCKS
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  // special-function register bus
  input  wire gpio_pad_pkg::sfr_req_type  sfrReq,
  output logic [7:0]                      sfrRdData,
  // paged external data address byte
  output logic [7:0]                      pagedExtDataHigh,
  // upper pins and pin-5 output bit of the lower port
  input  wire logic [1:0]                 upperPinIn,
  input  wire logic                       lowerPin5Out,
  // pad settings and status
  output gpio_pad_pkg::pad_ctrl_type      padCtrl,
  output logic                            padBusy
);

  gpio_pad_pkg::state_type st_r;
  gpio_pad_pkg::state_type st_nxt;

  // ---------------------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------------------
  // write strobe decode for one register
  function automatic logic hitWr(input gpio_pad_pkg::sfr_req_type r, input logic [7:0] a);
    hitWr = r.wrEn && (r.addr == a);
  endfunction

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // three-stage pin synchroniser, change taken when stages two and three agree
    st_nxt.pinSyncA = upperPinIn;
    st_nxt.pinSyncB = st_r.pinSyncA;
    st_nxt.pinSyncC = st_r.pinSyncB;
    for (int i = 0; i < 2; i++) begin
      if (st_r.pinSyncB[i] == st_r.pinSyncC[i]) begin
        st_nxt.pinStable[i] = st_r.pinSyncC[i];
      end
    end
    if (hitWr(sfrReq, `ADDR_EXTERNAL_DATA_SPACE_PAGE_BYTE)) begin
      st_nxt.pageByte = sfrReq.wrData;
    end
    if (hitWr(sfrReq, `ADDR_UPPER_PIN_DRIVE)) begin
      st_nxt.upperCfg = sfrReq.wrData[1:0];
    end
    if (hitWr(sfrReq, `ADDR_UPPER_PIN_DATA)) begin
      st_nxt.upperData = sfrReq.wrData[1:0];
    end
    if (hitWr(sfrReq, `ADDR_PAD_CONTROL)) begin
      st_nxt.strobe         = sfrReq.wrData[`BIT_STROBE];
      st_nxt.pullupOffReg   = sfrReq.wrData[`BIT_PULLUP_OFF];
      st_nxt.matrixReg      = sfrReq.wrData[`BIT_MATRIX];
      st_nxt.doubleDrive    = sfrReq.wrData[`BIT_DOUBLE_DRIVE];
      st_nxt.pin5HalfTrip   = sfrReq.wrData[`BIT_PIN5_HALF_TRIP];
      st_nxt.inputsHalfTrip = sfrReq.wrData[`BIT_INPUTS_HALF_TRIP];
      st_nxt.ledSel         = sfrReq.wrData[1:0];
    end
    // latches transparent while strobe is high; hold otherwise
    if (st_r.strobe) begin
      st_nxt.matrixLatch    = st_r.matrixReg;
      st_nxt.pullupOffLatch = st_r.pullupOffReg;
    end
    // strobe sequence then two clocks of pad update
    unique case (st_r.stbState)
      gpio_pad_pkg::STB_IDLE: begin
        if (st_r.strobe) begin
          st_nxt.stbState = gpio_pad_pkg::STB_OPEN;
        end
      end
      gpio_pad_pkg::STB_OPEN: begin
        if (!st_r.strobe) begin
          st_nxt.stbState = gpio_pad_pkg::STB_WAIT;
          // leaving open is the first update clock and leaving wait the last
          st_nxt.stbCount = 2'(UPDATE_CLOCKS - 2);
        end
      end
      gpio_pad_pkg::STB_WAIT: begin
        if (st_r.strobe) begin
          st_nxt.stbState = gpio_pad_pkg::STB_OPEN;
        end else if (st_r.stbCount == 2'h0) begin
          st_nxt.stbState = gpio_pad_pkg::STB_IDLE;
        end else begin
          st_nxt.stbCount = st_r.stbCount - 2'h1;
        end
      end
      default: st_nxt.stbState = gpio_pad_pkg::STB_IDLE;
    endcase
    st_nxt.padBusy = (st_nxt.stbState != gpio_pad_pkg::STB_IDLE);
    // register read mux
    st_nxt.rdData = 8'h00;
    if (sfrReq.rdEn) begin
      unique case (sfrReq.addr)
        `ADDR_EXTERNAL_DATA_SPACE_PAGE_BYTE: st_nxt.rdData = st_r.pageByte;
        `ADDR_UPPER_PIN_DRIVE: st_nxt.rdData = {6'h00, st_r.upperCfg};
        `ADDR_UPPER_PIN_DATA:  st_nxt.rdData = {6'h00, st_r.pinStable};
        `ADDR_PAD_CONTROL:     st_nxt.rdData = {st_r.strobe, st_r.pullupOffReg,
                                 st_r.matrixLatch, st_r.doubleDrive, st_r.pin5HalfTrip,
                                 st_r.inputsHalfTrip, st_r.ledSel};
        default:               st_nxt.rdData = 8'h00;
      endcase
    end
    // pad outputs
    // push-pull versus open-drain with pull-up
    st_nxt.pads.upperPushPull    = st_nxt.upperCfg;
    st_nxt.pads.upperPullupOn    = ~st_nxt.upperCfg;
    st_nxt.pads.upperOut         = st_nxt.upperData;
    st_nxt.pads.matrixLatched    = st_nxt.matrixLatch;
    st_nxt.pads.pullupOffLatched = st_nxt.pullupOffLatch;
    // matrix mode pulls pins 1 to 3 low
    st_nxt.pads.matrixPinsLow    = {3{st_nxt.matrixLatch}};
    st_nxt.pads.doubleDrive      = st_nxt.doubleDrive;
    st_nxt.pads.pin5HalfTrip     = st_nxt.pin5HalfTrip;
    st_nxt.pads.inputsHalfTrip   = st_nxt.inputsHalfTrip;
    st_nxt.pads.ledCurrentSel    = st_nxt.ledSel;
    // LED on only with nonzero field and pin-5 high
    st_nxt.pads.ledOn            = (st_nxt.ledSel != 2'h0) && lowerPin5Out;
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r                     <= '0;
      st_r.pageByte            <= `RST_EXTERNAL_DATA_SPACE_PAGE_BYTE;
      st_r.upperCfg            <= `RST_UPPER_PIN_DRIVE;
      st_r.upperData           <= `RST_UPPER_PIN_DATA;
      st_r.pin5HalfTrip        <= `RST_HALF_TRIP;
      st_r.inputsHalfTrip      <= `RST_HALF_TRIP;
      st_r.ledSel              <= `RST_LED_CURRENT;
      st_r.stbState            <= gpio_pad_pkg::STB_IDLE;
      st_r.pads.upperPullupOn  <= 2'h3;
      st_r.pads.upperOut       <= `RST_UPPER_PIN_DATA;
      st_r.pads.pin5HalfTrip   <= `RST_HALF_TRIP;
      st_r.pads.inputsHalfTrip <= `RST_HALF_TRIP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  // page byte as upper address
  assign pagedExtDataHigh = st_r.pageByte;
  assign sfrRdData        = st_r.rdData;
  assign padCtrl          = st_r.pads;
  assign padBusy          = st_r.padBusy;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // strobe register seen high, then low on the next edge
  sequence strobeFall_s;
    st_r.strobe ##1 !st_r.strobe;
  endsequence

  // strobe register held low for three edges
  sequence strobeLow3_s;
    !st_r.strobe [*3];
  endsequence

  // strobe register seen low, then high on the next edge
  sequence strobeRise_s;
    !st_r.strobe ##1 st_r.strobe;
  endsequence

  // page write followed on the next edge by a page read
  sequence pageWrRd_s;
    hitWr(sfrReq, `ADDR_EXTERNAL_DATA_SPACE_PAGE_BYTE) ##1
    (sfrReq.rdEn && sfrReq.addr == `ADDR_EXTERNAL_DATA_SPACE_PAGE_BYTE && !sfrReq.wrEn);
  endsequence

  // ---------------------------------------------------------------------------
  // upper pin configuration and data
  // ---------------------------------------------------------------------------
  // config reaches pads
  cfg_write_store_a: assert property (hitWr(sfrReq, `ADDR_UPPER_PIN_DRIVE) |=>
    padCtrl.upperPushPull == $past(sfrReq.wrData[1:0]) &&
    padCtrl.upperPullupOn == ~$past(sfrReq.wrData[1:0]))
    else $error("upper config not applied");

  cfg_hold_a: assert property (!hitWr(sfrReq, `ADDR_UPPER_PIN_DRIVE) |=>
    $stable(padCtrl.upperPushPull) && $stable(padCtrl.upperPullupOn))
    else $error("upper config changed without write");

  cfg_read_zero_a: assert property (sfrReq.rdEn &&
    sfrReq.addr == `ADDR_UPPER_PIN_DRIVE |=> sfrRdData[7:2] == 6'h00)
    else $error("unused config bits read nonzero");

  data_out_a: assert property (hitWr(sfrReq, `ADDR_UPPER_PIN_DATA) |=>
    padCtrl.upperOut == $past(sfrReq.wrData[1:0]))
    else $error("upper data not on pin outputs");

  pin_read_a: assert property (sfrReq.rdEn &&
    sfrReq.addr == `ADDR_UPPER_PIN_DATA |=> sfrRdData == {6'h00, $past(st_r.pinStable)})
    else $error("upper data read not from pins");

  sync_agree_a: assert property (st_r.pinSyncB == st_r.pinSyncC |=>
    st_r.pinStable == $past(st_r.pinSyncC))
    else $error("settled pin level not taken");

  // ---------------------------------------------------------------------------
  // page register
  // ---------------------------------------------------------------------------
  // write then read
  page_read_back_a: assert property (pageWrRd_s |=>
    sfrRdData == $past(sfrReq.wrData, 2))
    else $error("page register read mismatch");

  page_hold_a: assert property (!hitWr(sfrReq, `ADDR_EXTERNAL_DATA_SPACE_PAGE_BYTE) |=>
    $stable(pagedExtDataHigh))
    else $error("page byte changed without write");

  page_addr_out_a: assert property (hitWr(sfrReq, `ADDR_EXTERNAL_DATA_SPACE_PAGE_BYTE) |=>
    pagedExtDataHigh == $past(sfrReq.wrData))
    else $error("page byte not on address output");

  // ---------------------------------------------------------------------------
  // strobe and persistent latches
  // ---------------------------------------------------------------------------
  // matrix latch open
  latch_open_a: assert property (st_r.strobe |=>
    st_r.matrixLatch == $past(st_r.matrixReg))
    else $error("latch not transparent under strobe");

  pullup_open_a: assert property (st_r.strobe |=>
    st_r.pullupOffLatch == $past(st_r.pullupOffReg))
    else $error("pull-up latch not transparent under strobe");

  busy_rise_a: assert property (strobeRise_s |=> padBusy)
    else $error("pad busy not raised by strobe");

  update_done_a: assert property (strobeFall_s ##0 strobeLow3_s |-> !padBusy)
    else $error("pad update longer than two clocks");

  matrix_read_a: assert property (sfrReq.rdEn &&
    sfrReq.addr == `ADDR_PAD_CONTROL |=> sfrRdData[`BIT_MATRIX] == $past(st_r.matrixLatch))
    else $error("matrix read not from latch");

  matrix_drive_a: assert property (padCtrl.matrixLatched |->
    padCtrl.matrixPinsLow == 3'h7)
    else $error("matrix pins not driven low");

  matrix_release_a: assert property (!padCtrl.matrixLatched |->
    padCtrl.matrixPinsLow == 3'h0)
    else $error("matrix pins low without latch");

  latch_hold_a: assert property (!st_r.strobe |=>
    $stable(st_r.matrixLatch) && $stable(st_r.pullupOffLatch))
    else $error("latch changed without strobe");

  // ---------------------------------------------------------------------------
  // drive, trip point and LED settings
  // ---------------------------------------------------------------------------
  // drive doubling follows
  drive_follow_a: assert property (hitWr(sfrReq, `ADDR_PAD_CONTROL) |=>
    padCtrl.doubleDrive == $past(sfrReq.wrData[`BIT_DOUBLE_DRIVE]))
    else $error("drive doubling not applied");

  trip_follow_a: assert property (hitWr(sfrReq, `ADDR_PAD_CONTROL) |=>
    padCtrl.pin5HalfTrip == $past(sfrReq.wrData[`BIT_PIN5_HALF_TRIP]) &&
    padCtrl.inputsHalfTrip == $past(sfrReq.wrData[`BIT_INPUTS_HALF_TRIP]))
    else $error("trip point selection not applied");

  led_sel_a: assert property (hitWr(sfrReq, `ADDR_PAD_CONTROL) |=>
    padCtrl.ledCurrentSel == $past(sfrReq.wrData[1:0]))
    else $error("led current field not applied");

  led_gate_a: assert property (padCtrl.ledOn |->
    padCtrl.ledCurrentSel != 2'h0 && $past(lowerPin5Out))
    else $error("led on without enable");

  led_on_a: assert property (padCtrl.ledCurrentSel != 2'h0 && lowerPin5Out &&
    !hitWr(sfrReq, `ADDR_PAD_CONTROL) |=> padCtrl.ledOn)
    else $error("led off although enabled");

endmodule // gpio_pad_config_ctrl

`default_nettype wire

// file: src/gpio_pad_pkg.sv
// Purpose: types shared by the pad configuration block
// Assumes: constants come from gpio_pad_regs.svh
// Notes:   none
package gpio_pad_pkg;

  // register write/read request from the CPU special-function bus
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } sfr_req_type;

  // settings presented to the pads
  typedef struct packed {
    logic [1:0] upperPushPull;
    logic [1:0] upperPullupOn;
    logic [1:0] upperOut;
    logic       matrixLatched;
    logic       pullupOffLatched;
    logic [2:0] matrixPinsLow;
    logic       doubleDrive;
    logic       pin5HalfTrip;
    logic       inputsHalfTrip;
    logic [1:0] ledCurrentSel;
    logic       ledOn;
  } pad_ctrl_type;

  // strobe sequencer
  typedef enum logic [1:0] {
    STB_IDLE = 2'b00,
    STB_OPEN = 2'b01,
    STB_WAIT = 2'b10
  } strobe_state_type;

  // all state of the block
  typedef struct packed {
    logic [7:0]       pageByte;
    logic [1:0]       upperCfg;
    logic [1:0]       upperData;
    logic             strobe;
    logic             pullupOffReg;
    logic             matrixReg;
    logic             doubleDrive;
    logic             pin5HalfTrip;
    logic             inputsHalfTrip;
    logic [1:0]       ledSel;
    logic             matrixLatch;
    logic             pullupOffLatch;
    strobe_state_type stbState;
    logic [1:0]       stbCount;
    logic             padBusy;
    logic [7:0]       rdData;
    logic [1:0]       pinSyncA;
    logic [1:0]       pinSyncB;
    logic [1:0]       pinSyncC;
    logic [1:0]       pinStable;
    pad_ctrl_type     pads;
  } state_type;

endpackage

// file: src/gpio_pad_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: special-function-register space with 8-bit address and data
// Notes:   included by the design file
`ifndef GPIO_PAD_REGS_SVH
`define GPIO_PAD_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_UPPER_PIN_DATA     8'h90
`define ADDR_EXTERNAL_DATA_SPACE_PAGE_BYTE    8'hA0
`define ADDR_UPPER_PIN_DRIVE    8'hA5
`define ADDR_PAD_CONTROL        8'hB5

// ----------------------------------------------------------------------------
// pad_control field positions
// ----------------------------------------------------------------------------
`define BIT_STROBE              7
`define BIT_PULLUP_OFF          6
`define BIT_MATRIX              5
`define BIT_DOUBLE_DRIVE        4
`define BIT_PIN5_HALF_TRIP      3
`define BIT_INPUTS_HALF_TRIP    2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_EXTERNAL_DATA_SPACE_PAGE_BYTE     8'h00
`define RST_UPPER_PIN_DRIVE     2'h0
`define RST_UPPER_PIN_DATA      2'h3
`define RST_HALF_TRIP           1'h1
`define RST_LED_CURRENT         2'h0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PAD_UPDATE_CLOCKS       2

`endif

// file: test/gpio_pad_config_ctrl_tb.sv
// Purpose: self-checking bench for the pad configuration block
// Assumes: reads answer one cycle after rdEn
// Notes:   read results are checked from a queue of expected values
`timescale 1ns/1ns
`default_nettype none

module gpio_pad_config_ctrl_tb;
  localparam int UPD = 2;
  logic                      ref_clk = 1'b0;
  logic                      nrst = 1'b0;
  gpio_pad_pkg::sfr_req_type sfrReq = '0;
  logic [7:0]                sfrRdData, pagedExtDataHigh, v;
  logic [1:0]                pins, extLow = 2'h0;
  logic                      lowerPin5Out = 1'b0, padBusy, rdSeen = 1'b0;
  gpio_pad_pkg::pad_ctrl_type padCtrl;
  logic [7:0]                expQ[$];
  int                        miscompares = 0, comparisons = 0, cycles = 0, n, seed = 32499;

  always #5 ref_clk = ~ref_clk;

  gpio_pad_config_ctrl #(.UPDATE_CLOCKS(UPD)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .sfrReq(sfrReq), .sfrRdData(sfrRdData), .pagedExtDataHigh(pagedExtDataHigh),
    .upperPinIn(pins), .lowerPin5Out(lowerPin5Out), .padCtrl(padCtrl), .padBusy(padBusy));
  gpio_pad_model pads (.padCtrl(padCtrl), .extLow(extLow), .pinLevel(pins));

  task automatic finish_test();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) sfrReq <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk) sfrReq <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk) sfrReq <= {1'b0, 1'b1, a, 8'h00};
    expQ.push_back(e);
    @(posedge ref_clk) sfrReq <= '0;
  endtask

  // read result watcher, one cycle after the request
  always @(posedge ref_clk) begin
    if (rdSeen) chk(sfrRdData, expQ.pop_front());
    rdSeen <= sfrReq.rdEn;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    // reset values
    rd(8'hA0, 8'h00);
    rd(8'hA5, 8'h00);
    rd(8'hB5, 8'h0C);
    rd(8'h90, 8'h03);
    rd(8'h55, 8'h00);
    // page byte storage and address output
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      // write, then read back on the very next edge
      @(posedge ref_clk) sfrReq <= {1'b1, 1'b0, 8'hA0, v};
      @(posedge ref_clk) sfrReq <= {1'b0, 1'b1, 8'hA0, 8'h00};
      expQ.push_back(v);
      @(posedge ref_clk) sfrReq <= '0;
      #1 chk(pagedExtDataHigh, v);
    end
    wr(8'hA5, 8'hFF);
    rd(8'hA5, 8'h03);
    chk({6'h0, padCtrl.upperPushPull}, 8'h03);
    chk({6'h0, padCtrl.upperPullupOn}, 8'h00);
    wr(8'hA5, 8'hFD);
    #1 chk({6'h0, padCtrl.upperPullupOn}, 8'h02);
    // pin 1 as input, pin 0 pushed low
    wr(8'h90, 8'hFE);
    #1 chk({6'h0, padCtrl.upperOut}, 8'h02);
    v = {7'h0, 1'($random(seed))};
    extLow <= {v[0], 1'b0};
    repeat (6) @(posedge ref_clk);
    rd(8'h90, {6'h0, ~v[0], 1'b0});
    wr(8'hB5, 8'h60);
    @(posedge ref_clk) #1;
    chk({6'h0, padCtrl.matrixLatched, padCtrl.pullupOffLatched}, 8'h00);
    chk({5'h0, padCtrl.matrixPinsLow}, 8'h00);
    wr(8'hB5, 8'hE0);
    @(posedge ref_clk) #1;
    chk({6'h0, padCtrl.matrixLatched, padCtrl.pullupOffLatched}, 8'h03);
    chk({5'h0, padCtrl.matrixPinsLow}, 8'h07);
    chk({7'h0, padBusy}, 8'h01);
    // clearing strobe freezes, busy ends two clocks on
    @(posedge ref_clk) sfrReq <= {1'b1, 1'b0, 8'hB5, 8'h00};
    n = 0;
    do begin
      @(posedge ref_clk) sfrReq <= '0;
      #1 n++;
    end while (padBusy && n < 20);
    chk(8'(n), 8'(UPD + 1));
    chk({7'h0, padCtrl.matrixLatched}, 8'h01);
    // every LED code with pin 5 off and on
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk) lowerPin5Out <= i[2];
      wr(8'hB5, {6'h04, 2'(i)});
      repeat (2) @(posedge ref_clk);
      #1 chk({6'h0, padCtrl.ledCurrentSel}, 8'(i[1:0]));
      chk({7'h0, padCtrl.ledOn}, 8'(i[2] && i[1:0] != 0));
      chk({5'h0, padCtrl.doubleDrive, padCtrl.pin5HalfTrip, padCtrl.inputsHalfTrip},
          8'h04);
      rd(8'hB5, 8'h30 | 8'(i[1:0]));
    end
    repeat (3) @(posedge ref_clk);
    finish_test();
  end
endmodule // gpio_pad_config_ctrl_tb

`default_nettype wire

// file: test/gpio_pad_model.sv
// Purpose: behavioural upper pins as seen from outside the pad block
// Assumes: open-drain pins with pull-up read high when released
// Notes:   extLow stands for a button or load pulling a pin low
`timescale 1ns/1ns
`default_nettype none

module gpio_pad_model (
  // pad settings from the block
  input  wire gpio_pad_pkg::pad_ctrl_type padCtrl,
  // outside world
  input  wire logic [1:0]                 extLow,
  output logic [1:0]                      pinLevel
);
  // push-pull drives, open-drain only pulls low
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (extLow[i])
        pinLevel[i] = 1'b0;
      else if (padCtrl.upperPushPull[i])
        pinLevel[i] = padCtrl.upperOut[i];
      else
        pinLevel[i] = padCtrl.upperOut[i] & padCtrl.upperPullupOn[i];
    end
  end
endmodule // gpio_pad_model

`default_nettype wire
